// file: design/pwr_pkg.sv
/*
  Package for the power-mode and wakeup controller: register map, field
  positions, reset values, line counts and the power-mode state type.
  Assumes a 32-bit APB with byte addresses and one aligned word per register.
*/
// ==========================================================================
// Operation
// - Device stays held in reset while supply is below the power-on level.
// - Brownout reset supervisor is always active; nothing can switch it off.
// - Supply monitor interrupts on falling, rising or either threshold crossing.
// - Supply monitor stays inactive until software enables it; here only its edge line is gated, STATUS reads its level always.
// - Main regulation in run, low-power regulation in stop, power-down in standby.
// - Regulator enabled after every reset; high-impedance only during standby.
// - Sleep stops only the processor clock; any interrupt or event wakes it.
// - Stop halts core clocks and fast oscillators and PLL; contents kept.
// - Stop entry picks normal or low-power regulation by software selection.
// - Any edge-event line wakes stop: pin lines, monitor, RTC alarm.
// - Standby turns off regulator, fast oscillators and PLL; core state lost.
// - Standby exits on reset pin, watchdog reset, wake pin rise, RTC alarm.
// - RTC, independent watchdog and their clocks keep running in stop, standby.
// - Edge-event unit has 19 edge lines giving interrupt or event requests.
// - Each line has its own rising, falling or both trigger and own mask.
// - Each detected interrupt request sets a readable per-line pending bit.
// - Edge capture catches pulses as short as possible, with no filtering.
// - Up to 51 pins can be routed onto the 16 pin edge lines.
// ==========================================================================
`default_nettype none
package pwr_pkg;

  // ========================================================================
  // sizes
  localparam int NUM_LINES = 19;
  localparam int NUM_EXT   = 16;
  localparam int NUM_PINS  = 51;
  localparam int SEL_W     = 6;
  localparam int ADDR_W    = 8;
  localparam int LINE_MON  = 16;
  localparam int LINE_RTC  = 17;
  localparam int LINE_AUX  = 18;

  // ========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IMASK  = 8'h08;
  localparam logic [7:0] OFS_EMASK  = 8'h0C;
  localparam logic [7:0] OFS_RISE   = 8'h10;
  localparam logic [7:0] OFS_FALL   = 8'h14;
  localparam logic [7:0] OFS_PEND   = 8'h18;
  localparam logic [7:0] OFS_SRC0   = 8'h20;
  localparam logic [7:0] OFS_SRC3   = 8'h2C;

  // ========================================================================
  // control and status fields
  localparam int CTRL_STOP_LP  = 0;
  localparam int CTRL_STANDBY  = 1;
  localparam int CTRL_MON_EN   = 2;
  localparam int STAT_MON_LVL  = 0;
  localparam int STAT_WOKE_SBY = 1;
  localparam int SRC_FIELD_W   = 8;

  // ========================================================================
  // reset values
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [18:0] MASK_RST = 19'h00000;
  localparam logic [31:0] SRC_RST  = 32'h03020100;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_STOP,
    MODE_STANDBY
  } mode_e;

endpackage
`default_nettype wire

// file: design/edge_line.sv
/*
  One edge-event line: edge detector with trigger select and pending flag.
  Assumes the level input is synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module edge_line (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic wipe,
  input  wire logic level,
  input  wire logic rise_en,
  input  wire logic fall_en,
  input  wire logic pend_en,
  input  wire logic clear,
  output logic      hit,
  output logic      pend
);
  logic prev;

  // previous level, no filter so a one-cycle pulse is still an edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  // edge detect with per-line trigger select
  assign hit = (rise_en & level & ~prev) | (fall_en & ~level & prev);

  // pending flag, a new request wins over a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (wipe) begin
      pend <= 1'b0;
    end else begin
      pend <= (hit & pend_en) | (pend & ~clear);
    end
  end
endmodule
`default_nettype wire

// file: design/power_mode_wakeup_control.sv
/*
  Power-mode and wakeup controller with the edge-event unit and APB slave.
  Assumes all inputs synchronous to pclk; supply_ok and monitor_below come
  from analog comparators; the core raises sleep_req for one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module power_mode_wakeup_control #(
  parameter int LINES = pwr_pkg::NUM_LINES,
  parameter int PINS  = pwr_pkg::NUM_PINS
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pwr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       supply_ok,
  input  wire logic                       monitor_below,
  input  wire logic [PINS-1:0]            gpio_in,
  input  wire logic                       rtc_alarm,
  input  wire logic                       aux_line,
  input  wire logic                       sleep_req,
  input  wire logic                       sleep_deep,
  input  wire logic                       core_irq,
  input  wire logic                       external_reset_pin_n,
  input  wire logic                       watchdog_reset,
  input  wire logic                       wake_pin,
  output logic                            core_reset_n,
  output logic                            cpu_clk_en,
  output logic                            core_clk_en,
  output logic                            pll_en,
  output logic                            internal_fast_rc_en,
  output logic                            external_fast_oscillator_en,
  output logic                            low_speed_clk_en,
  output logic                            main_regulation,
  output logic                            low_power_regulation,
  output logic                            regulator_hiz,
  output logic      [LINES-1:0]           line_irq,
  output logic      [LINES-1:0]           line_evt
);
  import pwr_pkg::*;

  mode_e             state;
  mode_e             next_state;
  logic [2:0]        ctrl;
  logic [LINES-1:0]  imask;
  logic [LINES-1:0]  emask;
  logic [LINES-1:0]  rise_sel;
  logic [LINES-1:0]  fall_sel;
  logic [31:0]       src [4];
  logic              woke_standby;
  logic              wake_prev;
  logic [LINES-1:0]  line_lvl;
  logic [LINES-1:0]  hit;
  logic [LINES-1:0]  pend;
  logic [LINES-1:0]  clr;
  logic              wipe;
  logic              wr_ok;
  logic              rd_go;
  logic              mapped;
  logic              pend_wr;
  logic              sby_wake;
  logic              stop_wake;
  logic              sleep_wake;
  logic [31:0]       next_rdata;

  // ==========================================================================
  // helpers

  // routing field of one pin line, four lines per source register
  function automatic logic [SEL_W-1:0] src_of(input int idx,
                                               input logic [31:0] r [4]);
    logic [31:0] w;
    w = r[idx/4];
    return w[(idx%4)*SRC_FIELD_W +: SEL_W];
  endfunction

  // address is one of the implemented registers
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_IMASK) ||
           (a == OFS_EMASK) || (a == OFS_RISE) || (a == OFS_FALL) ||
           (a == OFS_PEND) || ((a >= OFS_SRC0) && (a <= OFS_SRC3) &&
           (a[1:0] == 2'b00));
  endfunction

  // ==========================================================================
  // supervisor and bus strobes

  // core-domain registers are lost under brownout and while in standby
  assign wipe = !supply_ok || (state == MODE_STANDBY);
  assign mapped = is_mapped(paddr);
  assign wr_ok = psel && penable && pwrite && pready && mapped;
  assign rd_go = psel && penable && !pready;
  assign pend_wr = wr_ok && (paddr == OFS_PEND);
  assign clr = pend_wr ? pwdata[LINES-1:0] : '0;

  // ==========================================================================
  // edge-event line sources

  // pin lines take a selectable pin, out-of-range selects read low
  generate
    for (genvar i = 0; i < NUM_EXT; i++) begin : g_pin_route
      logic [SEL_W-1:0] sel;
      assign sel = src_of(i, src);
      assign line_lvl[i] = (int'(sel) < PINS) ? gpio_in[sel] : 1'b0;
    end
  endgenerate

  // monitor only drives its line once software enables it
  assign line_lvl[LINE_MON] = ctrl[CTRL_MON_EN] & monitor_below;
  assign line_lvl[LINE_RTC] = rtc_alarm;
  assign line_lvl[LINE_AUX] = aux_line;

  // ==========================================================================
  // edge-event unit, one detector per line

  generate
    for (genvar i = 0; i < LINES; i++) begin : g_line
      edge_line u_line (
        .clk     (pclk),
        .rst_n   (presetn),
        .wipe    (wipe),
        .level   (line_lvl[i]),
        .rise_en (rise_sel[i]),
        .fall_en (fall_sel[i]),
        .pend_en (imask[i]),
        .clear   (clr[i]),
        .hit     (hit[i]),
        .pend    (pend[i])
      );
    end
  endgenerate

  // interrupt level follows unmasked pending, events are one-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_irq <= '0;
      line_evt <= '0;
    end else if (wipe) begin
      line_irq <= '0;
      line_evt <= '0;
    end else begin
      line_irq <= pend & imask;
      line_evt <= hit & emask;
    end
  end

  // ==========================================================================
  // power-mode sequencer

  assign sleep_wake = core_irq || (|(pend & imask)) || (|(hit & emask));
  assign stop_wake  = (|(pend & imask)) || (|(hit & emask));
  assign sby_wake   = !external_reset_pin_n || watchdog_reset ||
                      (wake_pin && !wake_prev) || rtc_alarm;

  // next power mode
  always_comb begin
    next_state = state;
    case (state)
      MODE_RUN: begin
        if (sleep_req && !sleep_deep) begin
          next_state = MODE_SLEEP;
        end else if (sleep_req && ctrl[CTRL_STANDBY]) begin
          next_state = MODE_STANDBY;
        end else if (sleep_req && !stop_wake) begin
          next_state = MODE_STOP;
        end
      end
      MODE_SLEEP: begin
        if (sleep_wake) begin
          next_state = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (stop_wake) begin
          next_state = MODE_RUN;
        end
      end
      MODE_STANDBY: begin
        if (sby_wake) begin
          next_state = MODE_RUN;
        end
      end
      default: next_state = MODE_RUN;
    endcase
  end

  // mode register, brownout forces run so release starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MODE_RUN;
    end else if (!supply_ok) begin
      state <= MODE_RUN;
    end else begin
      state <= next_state;
    end
  end

  // wake pin history and standby-exit flag, kept by standby circuitry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_prev    <= 1'b0;
      woke_standby <= 1'b0;
    end else begin
      wake_prev <= wake_pin;
      if (state == MODE_STANDBY && sby_wake) begin
        woke_standby <= 1'b1;
      end else if (wr_ok && paddr == OFS_STATUS && pwdata[STAT_WOKE_SBY]) begin
        woke_standby <= 1'b0;
      end
    end
  end

  // clock, oscillator and regulator controls follow the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n                <= 1'b0;
      cpu_clk_en                  <= 1'b1;
      core_clk_en                 <= 1'b1;
      pll_en                      <= 1'b1;
      internal_fast_rc_en         <= 1'b1;
      external_fast_oscillator_en <= 1'b1;
      low_speed_clk_en            <= 1'b1;
      main_regulation             <= 1'b1;
      low_power_regulation        <= 1'b0;
      regulator_hiz               <= 1'b0;
    end else begin
      core_reset_n                <= supply_ok && (state != MODE_STANDBY);
      cpu_clk_en                  <= (state == MODE_RUN);
      core_clk_en                 <= (state == MODE_RUN) || (state == MODE_SLEEP);
      pll_en                      <= (state == MODE_RUN) || (state == MODE_SLEEP);
      internal_fast_rc_en         <= (state == MODE_RUN) || (state == MODE_SLEEP);
      external_fast_oscillator_en <= (state == MODE_RUN) || (state == MODE_SLEEP);
      low_speed_clk_en            <= 1'b1;
      main_regulation             <= (state == MODE_RUN) || (state == MODE_SLEEP) ||
                                     (state == MODE_STOP && !ctrl[CTRL_STOP_LP]);
      low_power_regulation        <= (state == MODE_STOP) && ctrl[CTRL_STOP_LP];
      regulator_hiz               <= (state == MODE_STANDBY);
    end
  end

  // ==========================================================================
  // APB slave, one wait state per access

  // software-written configuration, lost with the core domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= CTRL_RST;
      imask    <= MASK_RST;
      emask    <= MASK_RST;
      rise_sel <= MASK_RST;
      fall_sel <= MASK_RST;
      for (int k = 0; k < 4; k++) begin
        src[k] <= SRC_RST;
      end
    end else if (wipe) begin
      ctrl     <= CTRL_RST;
      imask    <= MASK_RST;
      emask    <= MASK_RST;
      rise_sel <= MASK_RST;
      fall_sel <= MASK_RST;
      for (int k = 0; k < 4; k++) begin
        src[k] <= SRC_RST;
      end
    end else if (wr_ok) begin
      case (paddr)
        OFS_CTRL:  ctrl     <= pwdata[2:0];
        OFS_IMASK: imask    <= pwdata[LINES-1:0];
        OFS_EMASK: emask    <= pwdata[LINES-1:0];
        OFS_RISE:  rise_sel <= pwdata[LINES-1:0];
        OFS_FALL:  fall_sel <= pwdata[LINES-1:0];
        default: begin
          if (paddr >= OFS_SRC0) begin
            src[2'(paddr[3:2])] <= pwdata;
          end
        end
      endcase
    end
  end

  // read data mux, unused bits read zero
  always_comb begin
    next_rdata = 32'h00000000;
    case (paddr)
      OFS_CTRL:   next_rdata = {29'h00000000, ctrl};
      OFS_STATUS: next_rdata = {30'h00000000, woke_standby, monitor_below};
      OFS_IMASK:  next_rdata = {13'h0000, imask};
      OFS_EMASK:  next_rdata = {13'h0000, emask};
      OFS_RISE:   next_rdata = {13'h0000, rise_sel};
      OFS_FALL:   next_rdata = {13'h0000, fall_sel};
      OFS_PEND:   next_rdata = {13'h0000, pend};
      default: begin
        if (mapped && paddr >= OFS_SRC0) begin
          next_rdata = src[2'(paddr[3:2])];
        end
      end
    endcase
  end

  // ready after one wait state, error on unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= rd_go;
      pslverr <= rd_go && !mapped;
      if (rd_go && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // ==========================================================================
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wake_edge;
    state == MODE_STANDBY && wake_pin && !wake_prev;
  endsequence

  sequence s_pend_clear;
    pend_wr && pwdata[0] && !hit[0];
  endsequence

  a_reset_hold: assert property (
    !supply_ok |=> !core_reset_n ##1 !core_reset_n || supply_ok)
    else $error("core reset released while supply is low");
  a_monitor_quiet: assert property (!ctrl[CTRL_MON_EN] |-> !line_lvl[LINE_MON])
    else $error("supply monitor line active while disabled");
  a_standby_hiz: assert property (
    state == MODE_STANDBY |=> regulator_hiz && !main_regulation)
    else $error("regulator not high impedance in standby");
  a_stop_clocks: assert property (
    state == MODE_STOP |=> !core_clk_en && !pll_en && !external_fast_oscillator_en)
    else $error("core clocks or oscillators running in stop");
  a_stop_regsel: assert property (
    state == MODE_STOP && ctrl[CTRL_STOP_LP] |=> low_power_regulation && !main_regulation)
    else $error("stop regulation does not follow selection");
  a_sleep_cpu: assert property (state == MODE_SLEEP |=> !cpu_clk_en && core_clk_en)
    else $error("sleep clock gating wrong");
  a_standby_wake: assert property (s_wake_edge |=> state == MODE_RUN ##1 core_reset_n)
    else $error("wake pin rise did not leave standby");
  a_pend_w1c: assert property (s_pend_clear |=> !pend[0])
    else $error("pending bit survived write one");
  a_pend_set: assert property (
    hit[0] && imask[0] && !wipe |=> pend[0] ##1 line_irq[0] || !imask[0])
    else $error("edge did not set pending");
  a_masked_quiet: assert property (1'b1 |=> (line_irq & ~$past(imask)) == '0)
    else $error("masked line raised interrupt");
  a_lowspeed_run: assert property (state != MODE_RUN |-> ##1 low_speed_clk_en)
    else $error("low-speed clock stopped in low-power mode");
endmodule
`default_nettype wire

// file: verification/core_irq_model.sv
/*
  Behavioural model of the processor core and its interrupt controller.
  Assumes the controller's line_irq and line_evt outputs on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module core_irq_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [pwr_pkg::NUM_LINES-1:0] line_irq,
  input  wire logic [pwr_pkg::NUM_LINES-1:0] line_evt,
  input  wire logic                    soft_irq,
  output logic                         core_irq,
  output logic      [7:0]              evt_seen
);
  import pwr_pkg::*;
  // ==========================================================================
  // interrupt controller pends the core on any line or software request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq <= 1'b0;
    end else begin
      core_irq <= soft_irq | (|line_irq);
    end
  end
  // event counter stands in for the core's event input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_seen <= 8'h00;
    end else begin
      evt_seen <= evt_seen + 8'($countones(line_evt));
    end
  end
endmodule
`default_nettype wire

// file: verification/power_mode_wakeup_control_tb_top.sv
/*
  Self-checking bench for the power-mode and wakeup controller.
  Assumes APB with one wait state and the core model beside the design.
*/
`timescale 1ns/100ps
`default_nettype none
module power_mode_wakeup_control_tb_top;
  import pwr_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_ok, monitor_below;
  logic [7:0] paddr, evt_seen;
  logic [31:0] pwdata, prdata, rdv;
  logic [NUM_PINS-1:0] gpio_in;
  logic rtc_alarm, aux_line, sleep_req, sleep_deep, core_irq, soft_irq, erv;
  logic external_reset_pin_n, watchdog_reset, wake_pin, core_reset_n, cpu_clk_en;
  logic core_clk_en, pll_en, internal_fast_rc_en, external_fast_oscillator_en;
  logic low_speed_clk_en, main_regulation, low_power_regulation, regulator_hiz;
  logic [NUM_LINES-1:0] line_irq, line_evt;
  logic [7:0] e0;
  int fail_count, cmp_count;
  row_s rows[7];
  // ==========================================================================
  // design and partner
  power_mode_wakeup_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok), .monitor_below(monitor_below),
    .gpio_in(gpio_in), .rtc_alarm(rtc_alarm), .aux_line(aux_line), .sleep_req(sleep_req),
    .sleep_deep(sleep_deep), .core_irq(core_irq),
    .external_reset_pin_n(external_reset_pin_n), .watchdog_reset(watchdog_reset),
    .wake_pin(wake_pin), .core_reset_n(core_reset_n), .cpu_clk_en(cpu_clk_en),
    .core_clk_en(core_clk_en), .pll_en(pll_en), .internal_fast_rc_en(internal_fast_rc_en),
    .external_fast_oscillator_en(external_fast_oscillator_en),
    .low_speed_clk_en(low_speed_clk_en), .main_regulation(main_regulation),
    .low_power_regulation(low_power_regulation), .regulator_hiz(regulator_hiz),
    .line_irq(line_irq), .line_evt(line_evt));
  core_irq_model i_core (.pclk(pclk), .presetn(presetn), .line_irq(line_irq),
    .line_evt(line_evt), .soft_irq(soft_irq), .core_irq(core_irq), .evt_seen(evt_seen));
  // ==========================================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int n);
    @(posedge pclk);
    gpio_in[n] <= 1'b1;
    @(posedge pclk);
    gpio_in[n] <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  // core asks for a low-power mode with a one-cycle request
  task automatic enter(input logic deep);
    @(posedge pclk);
    sleep_deep <= deep;
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, gpio_in, monitor_below} = '0;
    {rtc_alarm, aux_line, sleep_req, sleep_deep, soft_irq, watchdog_reset, wake_pin} = '0;
    {presetn, supply_ok, external_reset_pin_n} = 3'b011;
    fail_count = 0;
    cmp_count = 0;
    rows = '{'{1'b0, OFS_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_IMASK, 32'h0, 32'h0, 1'b0},
             '{1'b0, OFS_SRC0, 32'h0, SRC_RST, 1'b0}, '{1'b0, OFS_SRC3, 32'h0, SRC_RST, 1'b0},
             '{1'b1, 8'h1C, 32'hFFFFFFFF, 32'h0, 1'b1},
             '{1'b1, OFS_FALL, 32'hFFFFFFFF, 32'h0007FFFF, 1'b0},
             '{1'b1, OFS_RISE, 32'hFFFFFFFF, 32'h0007FFFF, 1'b0}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk("run outputs", 32'hC,
        {core_reset_n, main_regulation, low_power_regulation, regulator_hiz});
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("reg read", rows[i].e, rdv);
      chk("reg error", {31'h0, rows[i].er}, {31'h0, erv});
    end
    // masked neighbour and write-one-to-clear
    apb(1'b1, OFS_FALL, 32'h0);
    apb(1'b1, OFS_IMASK, 32'h1);
    pulse(2);
    pulse(0);
    chk("line irq", 32'h1, {13'h0, line_irq});
    apb(1'b1, OFS_PEND, 32'h0);
    apb(1'b0, OFS_PEND, 32'h0);
    chk("pending kept", 32'h1, rdv);
    apb(1'b1, OFS_PEND, 32'h1);
    apb(1'b0, OFS_PEND, 32'h0);
    chk("pending cleared", 32'h0, rdv);
    // falling-only line and event request
    apb(1'b1, OFS_RISE, 32'h1);
    apb(1'b1, OFS_FALL, 32'h2);
    apb(1'b1, OFS_IMASK, 32'h3);
    apb(1'b1, OFS_EMASK, 32'h1);
    pulse(1);
    apb(1'b0, OFS_PEND, 32'h0);
    chk("fall pending", 32'h2, rdv);
    apb(1'b1, OFS_PEND, 32'hFFFFFFFF);
    apb(1'b1, OFS_IMASK, 32'h0);
    e0 = evt_seen;
    pulse(0);
    chk("event count", 32'h1, {24'h0, evt_seen - e0});
    // sleep and wake by core interrupt
    enter(1'b0);
    chk("sleep clocks", 32'h1, {30'h0, cpu_clk_en, core_clk_en});
    @(posedge pclk);
    soft_irq <= 1'b1;
    repeat (5) @(posedge pclk);
    soft_irq <= 1'b0;
    #1;
    chk("sleep wake", 32'h1, {31'h0, cpu_clk_en});
    // stop with low-power regulation, woken by an event line
    apb(1'b1, OFS_CTRL, 32'h1);
    enter(1'b1);
    chk("stop clocks", 32'h0,
        {core_clk_en, pll_en, internal_fast_rc_en, external_fast_oscillator_en});
    chk("stop reg", 32'h6,
        {low_power_regulation, low_speed_clk_en, main_regulation});
    pulse(0);
    chk("stop wake", 32'h1, {31'h0, core_clk_en});
    // supply monitor, off then on, both crossings
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_IMASK, 32'h10000);
    apb(1'b1, OFS_FALL, 32'h10000);
    apb(1'b1, OFS_RISE, 32'h10000);
    monitor_below <= 1'b1;
    apb(1'b0, OFS_PEND, 32'h0);
    chk("monitor off", 32'h0, rdv);
    monitor_below <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h4);
    monitor_below <= 1'b1;
    apb(1'b0, OFS_PEND, 32'h0);
    chk("monitor fell", 32'h10000, rdv);
    apb(1'b1, OFS_PEND, 32'h10000);
    monitor_below <= 1'b0;
    apb(1'b0, OFS_PEND, 32'h0);
    chk("monitor rose", 32'h10000, rdv);
    apb(1'b1, OFS_PEND, 32'hFFFFFFFF);
    // standby and exit by wake pin rise
    apb(1'b1, OFS_CTRL, 32'h2);
    enter(1'b1);
    chk("standby outs", 32'h3,
        {core_reset_n, main_regulation, pll_en, regulator_hiz, low_speed_clk_en});
    @(posedge pclk);
    wake_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    wake_pin <= 1'b0;
    #1;
    chk("standby exit", 32'h2, {30'h0, core_reset_n, regulator_hiz});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("woke flag", 32'h2, rdv & 32'h2);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("config lost", 32'h0, rdv);
    // standby exit by rtc alarm, watchdog reset and reset pin in turn
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_CTRL, 32'h2);
      enter(1'b1);
      chk("standby entered", 32'h1, {31'h0, regulator_hiz});
      @(posedge pclk);
      {rtc_alarm, watchdog_reset, external_reset_pin_n} <= {k == 0, k == 1, k != 2};
      repeat (3) @(posedge pclk);
      {rtc_alarm, watchdog_reset, external_reset_pin_n} <= 3'b001;
      #1;
      chk("standby source", 32'h2, {30'h0, core_reset_n, regulator_hiz});
    end
    // supply below power-on level holds the core in reset
    supply_ok <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk("supply low", 32'h1, {30'h0, core_reset_n, main_regulation});
    supply_ok <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("supply back", 32'h1, {31'h0, core_reset_n});
    end_of_test();
  end
endmodule
`default_nettype wire
